//--- core/cdj_decoder.sv
`timescale 1ns/10ps
`include "cdj_map.svh"
`default_nettype none
module cdj_decoder
  import cdj_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_data,
  input wire logic [2:0] fifo_valid,
  input wire logic [3:0] fifo_status,
  input wire logic fifo_eol,
  output logic [2:0] fifo_pop,
  output logic irq
);
  cdj_state_t state_reg, state_next;
  logic run_reg, run_next;
  logic widx_reg, widx_next;
  logic abort_reg, abort_next;
  logic reported_reg, reported_next;
  logic [31:0] pc_reg, pc_next;
  logic [31:0] start_reg, start_next;
  logic [31:0] dw0_reg, dw0_next;
  logic [3:0] flags_reg, flags_next;
  logic [3:0] stat_reg, stat_next;
  logic [3:0] mask_reg, mask_next;
  logic [11:0] cnt_reg [3];
  logic [11:0] cnt_next [3];
  logic [1:0] off_reg [3];
  logic [1:0] off_next [3];
  logic aw_full_reg, aw_full_next;
  logic w_full_reg, w_full_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [2:0] lane_want, lane_pop, lane_go;
  logic [1:0] lane_off [3];
  logic [11:0] lane_cnt [3];

  // Byte position inside the head DWORD of each FIFO
  for (genvar i = 0; i < 3; i++) begin : g_lane
    logic [2:0] room;
    logic [2:0] take;
    logic [2:0] sum;
    always_comb begin
      room = 3'h4 - {1'b0, off_reg[i]};
      take = (cnt_reg[i] < {9'h000, room}) ? cnt_reg[i][2:0] : room;
      sum = {1'b0, off_reg[i]} + take;
    end
    assign lane_want[i] = cnt_reg[i] != 12'h000;
    assign lane_pop[i] = sum[2];
    assign lane_off[i] = sum[1:0];
    assign lane_cnt[i] = cnt_reg[i] - {9'h000, take};
  end

  assign lane_go[0] = state_reg == CDJ_S_EXEC && lane_want[0] && fifo_valid[0];
  // Chroma lanes move together while both have bytes left, so neither runs ahead of the other
  assign lane_go[1] = state_reg == CDJ_S_EXEC && lane_want[1] && fifo_valid[1]
    && (!lane_want[2] || fifo_valid[2]);
  assign lane_go[2] = state_reg == CDJ_S_EXEC && lane_want[2] && fifo_valid[2]
    && (!lane_want[1] || fifo_valid[1]);

  function automatic logic [3:0] flag_update(input logic [3:0] f, input logic [31:0] d);
    flag_update = (f & ~d[`CDJ_F_CLR]) | d[`CDJ_F_SET];
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    strb_merge = (old & ~m) | (d & m);
  endfunction

  always_comb begin
    logic [3:0] ev;
    logic [3:0] clr;
    logic [3:0] op;
    logic [31:0] wm;
    logic [15:0] rsvd;
    ev = 4'h0;
    clr = 4'h0;
    op = fetch_data[`CDJ_F_OP];
    wm = 32'h0000_0000;
    rsvd = `CDJ_ALIGN_RSVD;
    state_next = state_reg;
    run_next = run_reg;
    widx_next = widx_reg;
    abort_next = abort_reg;
    reported_next = reported_reg;
    pc_next = pc_reg;
    start_next = start_reg;
    dw0_next = dw0_reg;
    flags_next = flags_reg;
    mask_next = mask_reg;
    cnt_next = cnt_reg;
    off_next = off_reg;
    fifo_pop = 3'h0;
    fetch_req = state_reg == CDJ_S_FETCH;
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;

    unique case (state_reg)
      CDJ_S_IDLE: begin
      end
      CDJ_S_FETCH: begin
        if (fetch_valid) begin
          pc_next = pc_reg + 32'h0000_0004;
          if (!widx_reg) begin
            dw0_next = fetch_data;
            if (op == `CDJ_OP_DISCARD) begin
              flags_next = flag_update(flags_reg, fetch_data);
              ev[`CDJ_EV_IRQ] = fetch_data[`CDJ_F_IRQ];
              cnt_next[0] = fetch_data[`CDJ_F_CNT_LO];
              if (abort_reg) begin
                abort_next = !fetch_data[`CDJ_F_LAST];
              end else begin
                state_next = CDJ_S_EXEC;
              end
            end else if (op == `CDJ_OP_PLANAR || op == `CDJ_OP_BRANCH
                         || op == `CDJ_OP_ALIGN) begin
              widx_next = 1'b1;
            end else begin
              // Stop rather than run through memory that is not a program
              ev[`CDJ_EV_ERR] = 1'b1;
              run_next = 1'b0;
              state_next = CDJ_S_IDLE;
            end
          end else begin
            widx_next = 1'b0;
            flags_next = flag_update(flags_reg, dw0_reg);
            ev[`CDJ_EV_IRQ] = dw0_reg[`CDJ_F_IRQ];
            unique case (dw0_reg[`CDJ_F_OP])
              `CDJ_OP_PLANAR: begin
                cnt_next[0] = dw0_reg[`CDJ_F_CNT_LO];
                cnt_next[1] = fetch_data[`CDJ_F_CNT_LO];
                cnt_next[2] = fetch_data[`CDJ_F_CNT_HI];
                if (abort_reg) begin
                  abort_next = !dw0_reg[`CDJ_F_LAST];
                end else begin
                  state_next = CDJ_S_EXEC;
                end
              end
              `CDJ_OP_BRANCH: begin
                pc_next = {fetch_data[31:2], 2'h0};
              end
              default: begin
                if (rsvd[dw0_reg[`CDJ_F_CODE]]) begin
                  ev[`CDJ_EV_ERR] = 1'b1;
                  run_next = 1'b0;
                  state_next = CDJ_S_IDLE;
                end else begin
                  reported_next = 1'b0;
                  state_next = CDJ_S_SYNC;
                end
              end
            endcase
          end
        end
      end
      CDJ_S_EXEC: begin
        for (int i = 0; i < 3; i++) begin
          if (lane_go[i]) begin
            cnt_next[i] = lane_cnt[i];
            off_next[i] = lane_off[i];
            fifo_pop[i] = lane_pop[i];
          end
        end
        // Line ended in the FIFO before the program expected it
        if (lane_go[0] && lane_pop[0] && fifo_eol
            && (!dw0_reg[`CDJ_F_LAST] || lane_cnt[0] != 12'h000)) begin
          ev[`CDJ_EV_EOL] = 1'b1;
          abort_next = !dw0_reg[`CDJ_F_LAST];
          cnt_next[0] = 12'h000;
          cnt_next[1] = 12'h000;
          cnt_next[2] = 12'h000;
        end
        if (lane_want == 3'h0) begin
          state_next = CDJ_S_FETCH;
        end
      end
      CDJ_S_SYNC: begin
        if (fifo_valid[0]) begin
          if (fifo_status == dw0_reg[`CDJ_F_CODE]) begin
            off_next[0] = 2'h0;
            state_next = CDJ_S_FETCH;
          end else begin
            fifo_pop[0] = 1'b1;
            // One report per alignment keeps the status from flooding
            if (!dw0_reg[`CDJ_F_NOERR] && !reported_reg) begin
              ev[`CDJ_EV_REALIGN] = 1'b1;
              reported_next = 1'b1;
            end
          end
        end
      end
      default: begin
        state_next = CDJ_S_IDLE;
      end
    endcase

    if (awvalid && !aw_full_reg) begin
      aw_full_next = 1'b1;
      aw_addr_next = awaddr;
    end
    if (wvalid && !w_full_reg) begin
      w_full_next = 1'b1;
      w_data_next = wdata;
      w_strb_next = wstrb;
    end
    if (aw_full_reg && w_full_reg && !bvalid_reg) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `CDJ_RESP_OK;
      wm = strb_merge(32'h0000_0000, w_data_reg, w_strb_reg);
      unique case (aw_addr_reg)
        `CDJ_A_CTRL: begin
          if (w_strb_reg[0]) begin
            run_next = w_data_reg[0];
            widx_next = 1'b0;
            abort_next = 1'b0;
            pc_next = start_reg;
            state_next = w_data_reg[0] ? CDJ_S_FETCH : CDJ_S_IDLE;
          end
        end
        `CDJ_A_START: start_next = strb_merge(start_reg, w_data_reg, w_strb_reg);
        `CDJ_A_STAT: clr = wm[3:0];
        `CDJ_A_MASK: mask_next = w_strb_reg[0] ? w_data_reg[3:0] : mask_reg;
        `CDJ_A_PC, `CDJ_A_FLAGS: begin
        end
        default: bresp_next = `CDJ_RESP_ERR;
      endcase
    end
    if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end

    if (arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = `CDJ_RESP_OK;
      unique case (araddr)
        `CDJ_A_CTRL: rdata_next = {31'h0, run_reg};
        `CDJ_A_START: rdata_next = start_reg;
        `CDJ_A_PC: rdata_next = pc_reg;
        `CDJ_A_STAT: rdata_next = {28'h0, stat_reg};
        `CDJ_A_MASK: rdata_next = {28'h0, mask_reg};
        `CDJ_A_FLAGS: rdata_next = {28'h0, flags_reg};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = `CDJ_RESP_ERR;
        end
      endcase
    end else if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end

    // A new event beats a clear written in the same cycle
    stat_next = (stat_reg & ~clr) | ev;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= CDJ_S_IDLE;
      run_reg <= 1'b0;
      widx_reg <= 1'b0;
      abort_reg <= 1'b0;
      reported_reg <= 1'b0;
      pc_reg <= 32'h0000_0000;
      start_reg <= 32'h0000_0000;
      dw0_reg <= 32'h0000_0000;
      flags_reg <= 4'h0;
      stat_reg <= 4'h0;
      mask_reg <= 4'h0;
      cnt_reg <= '{3{12'h000}};
      off_reg <= '{3{2'h0}};
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      run_reg <= run_next;
      widx_reg <= widx_next;
      abort_reg <= abort_next;
      reported_reg <= reported_next;
      pc_reg <= pc_next;
      start_reg <= start_next;
      dw0_reg <= dw0_next;
      flags_reg <= flags_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      cnt_reg <= cnt_next;
      off_reg <= off_next;
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign awready = !aw_full_reg;
  assign wready = !w_full_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = !rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign fetch_addr = pc_reg;
  assign irq = (stat_reg & mask_reg) != 4'h0;
endmodule // cdj_decoder
`default_nettype wire

//--- core/cdj_map.svh
`ifndef CDJ_MAP_SVH
`define CDJ_MAP_SVH
`define CDJ_OP_DISCARD 4'h2
`define CDJ_OP_PLANAR 4'ha
`define CDJ_OP_BRANCH 4'h7
`define CDJ_OP_ALIGN 4'h8
`define CDJ_F_OP 31:28
`define CDJ_F_FIRST 27
`define CDJ_F_LAST 26
`define CDJ_F_IRQ 24
`define CDJ_F_CLR 23:20
`define CDJ_F_SET 19:16
`define CDJ_F_NOERR 15
`define CDJ_F_CODE 3:0
`define CDJ_F_CNT_LO 11:0
`define CDJ_F_CNT_HI 27:16
`define CDJ_ALIGN_RSVD 16'h0001
`define CDJ_A_CTRL 8'h00
`define CDJ_A_START 8'h04
`define CDJ_A_PC 8'h08
`define CDJ_A_STAT 8'h0c
`define CDJ_A_MASK 8'h10
`define CDJ_A_FLAGS 8'h14
`define CDJ_EV_IRQ 0
`define CDJ_EV_ERR 1
`define CDJ_EV_REALIGN 2
`define CDJ_EV_EOL 3
`define CDJ_RESP_OK 2'h0
`define CDJ_RESP_ERR 2'h2
`endif

//--- core/cdj_pkg.sv
package cdj_pkg;
  typedef enum logic [3:0] {
    CDJ_S_IDLE = 4'h1,
    CDJ_S_FETCH = 4'h2,
    CDJ_S_EXEC = 4'h4,
    CDJ_S_SYNC = 4'h8
  } cdj_state_t;
endpackage

//--- test/capture_dma_risc_skip_jump_sync_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module capture_dma_risc_skip_jump_sync_tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fetch_req, fetch_valid, irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, fetch_addr, fetch_data, last_fa;
  logic [1:0] bresp, rresp, wr_resp;
  logic [2:0] fifo_pop;
  logic [3:0] fifo_status = 4'h3;
  logic [2:0] fifo_valid = 3'h7;
  logic fifo_eol = 1'b0, gap = 1'b0, pops_clr = 1'b0, split = 1'b0;
  int pops [3] = '{0, 0, 0};
  int failures = 0, samples_checked = 0;
  always #2.5 clock = ~clock;
  cdj_decoder u_dut (.clock(clock), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
    .bvalid(bvalid), .bready(1'b1), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(1'b1), .rdata(rdata), .rresp(rresp),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
    .fetch_data(fetch_data), .fifo_valid(fifo_valid), .fifo_status(fifo_status),
    .fifo_eol(fifo_eol),
    .fifo_pop(fifo_pop), .irq(irq));
  cdj_host_mem u_mem (.clock(clock), .rst_n(rst_n), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .fetch_data(fetch_data));
  // Head status turns to the match code right after the third pop
  // In a gap the third FIFO stays empty until luma has popped twice
  always @(posedge clock) begin
    if (pops_clr) begin
      pops <= '{0, 0, 0};
      split <= 1'b0;
      fifo_status <= 4'h3;
    end else begin
      for (int i = 0; i < 3; i++) pops[i] <= pops[i] + int'(fifo_pop[i]);
      fifo_status <= (pops[0] + int'(fifo_pop[0]) >= 3) ? 4'h5 : 4'h3;
      if (fifo_pop[1] != fifo_pop[2]) split <= 1'b1;
    end
    fifo_valid <= {!gap || pops[0] >= 2, 2'h3};
    if (fetch_valid) last_fa <= fetch_addr;
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clock); while (!bvalid);
    wr_resp = bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    `CHK(d, e)
  endtask
  task automatic run_prog(input logic [31:0] base);
    logic [31:0] d;
    logic [1:0] r;
    pops_clr <= 1'b1;
    @(posedge clock);
    pops_clr <= 1'b0;
    axi_wr(8'h04, base);
    axi_wr(8'h00, 32'h1);
    for (int i = 0; i < 200; i++) begin
      axi_rd(8'h00, d, r);
      if (d[0] === 1'b0) break;
    end
    `CHK(d[0], 1'b0)
  endtask
  task automatic test_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h0c, 32'h0);
    axi_rd(8'h20, d, r);
    `CHK(r, 2'h2)
    axi_wr(8'h20, 32'h1);
    `CHK(wr_resp, 2'h2)
    axi_wr(8'h10, 32'hf);
    rd_chk(8'h10, 32'hf);
    $display("test regs done");
  endtask
  task automatic test_discard();
    u_mem.mem[0] = 32'h2d050006;
    u_mem.mem[1] = 32'h2c000002;
    u_mem.mem[2] = 32'h0;
    run_prog(32'h0);
    `CHK(pops[0], 2)
    rd_chk(8'h14, 32'h5);
    rd_chk(8'h0c, 32'h3);
    `CHK(irq, 1'b1)
    axi_wr(8'h10, 32'h0);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b0)
    axi_wr(8'h10, 32'hf);
    axi_wr(8'h0c, 32'h3);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b0)
    $display("test discard done");
  endtask
  task automatic test_planar();
    u_mem.delay = 3;
    u_mem.mem[8] = 32'hac000008;
    u_mem.mem[9] = 32'h00040004;
    u_mem.mem[10] = 32'h70000000;
    u_mem.mem[11] = 32'h00000040;
    u_mem.mem[16] = 32'hf0000000;
    gap <= 1'b1;
    run_prog(32'h20);
    gap <= 1'b0;
    `CHK(pops[0], 2)
    `CHK(pops[1], 1)
    `CHK(pops[2], 1)
    `CHK(split, 1'b0)
    `CHK(last_fa, 32'h40)
    rd_chk(8'h08, 32'h44);
    rd_chk(8'h0c, 32'h2);
    axi_wr(8'h0c, 32'hf);
    $display("test planar done");
  endtask
  task automatic test_align();
    logic [31:0] op [3] = '{32'h80000005, 32'h80008005, 32'h80000000};
    u_mem.delay = 0;
    for (int k = 0; k < 3; k++) begin
      u_mem.mem[24] = op[k];
      u_mem.mem[25] = 32'h0;
      u_mem.mem[26] = 32'h0;
      run_prog(32'h60);
      `CHK(pops[0], (k < 2) ? 3 : 0)
      rd_chk(8'h0c, (k == 0) ? 32'h6 : 32'h2);
      axi_wr(8'h0c, 32'hf);
    end
    $display("test align done");
  endtask
  // Every luma DWORD ends a line, so each pop without the last flag aborts
  task automatic test_eol();
    u_mem.mem[32] = 32'h28000008;
    u_mem.mem[33] = 32'h20000004;
    u_mem.mem[34] = 32'h24000004;
    u_mem.mem[35] = 32'h20000004;
    u_mem.mem[36] = 32'h0;
    fifo_eol <= 1'b1;
    run_prog(32'h80);
    fifo_eol <= 1'b0;
    `CHK(pops[0], 2)
    rd_chk(8'h0c, 32'ha);
    axi_wr(8'h0c, 32'hf);
    $display("test eol done");
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    test_regs();
    test_discard();
    test_planar();
    test_align();
    test_eol();
    close_out();
  end
  initial begin
    #50000;
    failures++;
    close_out();
  end
endmodule // capture_dma_risc_skip_jump_sync_tb_top
`default_nettype wire

//--- test/cdj_decoder_checker.sv
`timescale 1ns/10ps
`default_nettype none
module cdj_decoder_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic fetch_req,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic [2:0] fifo_valid,
  input wire logic [2:0] fifo_pop,
  input wire logic irq,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_write_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  a_pop_valid: assert property ((fifo_pop & ~fifo_valid) == 3'h0)
    else $error("pop without head");
  a_pop_fetch: assert property (fifo_pop != 3'h0 |-> !fetch_req)
    else $error("pop while fetching");
  a_addr_hold: assert property (fetch_req && !fetch_valid |=> $stable(fetch_addr))
    else $error("fetch address moved");
  a_addr_align: assert property (fetch_req |-> fetch_addr[1:0] == 2'h0)
    else $error("fetch address unaligned");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !irq && !fetch_req)
    else $error("busy after reset");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("late read data");
  a_read_block: assert property (rvalid |-> !arready)
    else $error("read taken while data held");
  a_write_answer: assert property (s_write_taken |-> ##2 bvalid)
    else $error("late write response");
endmodule // cdj_decoder_checker
bind cdj_decoder cdj_decoder_checker u_chk (.clock(clock), .rst_n(rst_n),
  .fetch_req(fetch_req), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
  .fifo_valid(fifo_valid), .fifo_pop(fifo_pop), .irq(irq), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid));
`default_nettype wire

//--- test/cdj_host_mem.sv
`timescale 1ns/10ps
`default_nettype none
module cdj_host_mem (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  output logic fetch_valid,
  output logic [31:0] fetch_data
);
  logic [31:0] mem [0:63];
  int delay = 0;
  int wait_cnt = 0;
  initial begin
    fetch_valid = 1'b0;
    fetch_data = 32'h0;
  end
  // Junk outside the answer cycle, so a late sample is caught
  always @(posedge clock) begin
    fetch_valid <= 1'b0;
    fetch_data <= ~fetch_data;
    if (!rst_n || !fetch_req || fetch_valid) begin
      wait_cnt <= 0;
    end else if (wait_cnt < delay) begin
      wait_cnt <= wait_cnt + 1;
    end else begin
      fetch_valid <= 1'b1;
      fetch_data <= mem[fetch_addr[7:2]];
    end
  end
endmodule // cdj_host_mem
`default_nettype wire
